// ===== core/sbsc_pkg.sv
// Shared widths, reset values and state carriers of the burst SRAM control.
package sbsc_pkg;

  // Widths of the device as built.
  localparam int ADDR_WIDTH = 21;
  localparam int LANES      = 4;
  localparam int LANE_WIDTH = 9;
  localparam int DATA_WIDTH = LANES * LANE_WIDTH;
  localparam int BURST_BITS = 2;
  localparam int HI_WIDTH   = ADDR_WIDTH - BURST_BITS;

  // Sleep entry and exit latency, in clock cycles.
  localparam int SLEEP_CYCLES = 2;

  // Reset values and lane and step constants.
  localparam logic                  RST_INTERLEAVE = 1'b1;
  localparam logic [LANES-1:0]      NO_LANES       = 4'h0;
  localparam logic [LANES-1:0]      ALL_LANES      = 4'hf;
  localparam logic [BURST_BITS-1:0] STEP_ZERO      = 2'h0;
  localparam logic [BURST_BITS-1:0] STEP_ONE       = 2'h1;

  // Kind of access decoded at a clock rise.
  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_DESELECT,
    CYC_BEGIN_READ,
    CYC_BEGIN_WRITE,
    CYC_NEXT,
    CYC_CURRENT
  } sbsc_cycle_t;

  // Inputs from the processor or cache controller side.
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic                  chip_sel_primary_n;
    logic                  chip_sel_expand_hi;
    logic                  chip_sel_expand_lo_n;
    logic                  processor_addr_strobe_n;
    logic                  controller_addr_strobe_n;
    logic                  burst_advance_n;
    logic                  global_write_n;
    logic                  byte_write_gate_n;
    logic [LANES-1:0]      byte_lane_write_n;
    logic                  output_enable_n;
  } sbsc_bus_t;

  // Port towards the storage array.
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [LANES-1:0]      write_lanes;
    logic [DATA_WIDTH-1:0] wdata;
    logic                  read;
  } sbsc_mem_t;

  // Every flip-flop of the block.
  typedef struct packed {
    logic                  sleep_sync1;
    logic                  sleep_sync2;
    logic                  interleave;
    logic                  mode_taken;
    logic                  active;
    logic [HI_WIDTH-1:0]   addr_hi;
    logic [BURST_BITS-1:0] start;
    logic [BURST_BITS-1:0] step;
    sbsc_mem_t             mem;
    logic [DATA_WIDTH-1:0] dq_out;
    logic                  dq_oe_n;
  } sbsc_state_t;

  localparam sbsc_state_t RST_STATE = '{
    sleep_sync1: 1'b0,
    sleep_sync2: 1'b0,
    interleave:  RST_INTERLEAVE,
    mode_taken:  1'b0,
    active:      1'b0,
    addr_hi:     '0,
    start:       STEP_ZERO,
    step:        STEP_ZERO,
    mem:         '0,
    dq_out:      '0,
    dq_oe_n:     1'b1
  };

endpackage

// ===== core/sbsc_top.sv
// Cycle decode, burst counter, data drive and sleep control of the SRAM.
//
// How it works
// RQ1 - Controller strobe with all selects, processor strobe high, write decode starts write.
// RQ2 - Controller-strobe write loads address and counter, writes presented data same cycle.
// RQ3 - Any detected write, even partial, turns the data lines off regardless of enable.
// RQ4 - Far side releases output enable and lets lines float before driving write data.
// RQ5 - Two-bit wrapping counter, loaded from address bits one and zero, supplies low bits.
// RQ6 - Order input low means linear, high means interleaved; floating defaults to interleaved.
// RQ7 - Interleaved order XORs the starting value with zero, one, two, three in turn.
// RQ8 - Linear order adds one to the low two address bits per step, modulo four.
// RQ9 - Sleep input is asynchronous; asserting it enters low power keeping contents.
// RQ10 - Sleep entry and exit take two cycles each; pending accesses are dropped.
// RQ11 - Far side deselects before sleep and stays idle two cycles after release.
// RQ12 - Deselect with lines off on the two documented chip select and strobe cases.
// RQ13 - While asleep every other input is ignored and the data lines stay off.
// RQ14 - Accepted processor strobe with all selects always begins a read; it is ignored with primary deselected.
// RQ15 - No accepted strobe and advance low steps to the next burst address.
// RQ16 - No accepted strobe and advance high repeats the access at the current address.
// RQ17 - Write decode is global write low, or gate low with any lane low.
// RQ18 - Writes follow a processor start or come with a controller start only; the code also writes in any later burst cycle, after either start.
// RQ19 - Output enable drives reads, masked during writes and while deselected.
// RQ20 - Any lane mix is valid per byte and parity; global write writes all four.
// RQ21 - Write inputs ignored in a processor start cycle, used from the next rise.
`timescale 1ns/1ps
`default_nettype none

module sbsc_top
  import sbsc_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int DATA_W = DATA_WIDTH
) (
  // Clock, reset and clock enable.
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  input  wire logic                  CLK_EN,
  // Burst order strap, high for interleaved.
  input  wire logic                  BURST_ORDER_INTERLEAVE,
  // Sleep request from the far side.
  input  wire logic                  SLEEP_REQUEST,
  // Address, selects, strobes and write controls.
  input  wire sbsc_bus_t             BUS,
  // Common data lines, split into three signals.
  input  wire logic [DATA_W-1:0]     DQ_IN,
  output logic      [DATA_W-1:0]     DQ_OUT,
  output logic                       DQ_OE_N,
  // Storage array port.
  output sbsc_mem_t                  MEM,
  input  wire logic [DATA_W-1:0]     MEM_RDATA,
  // Status.
  output logic                       SLEEP_STATE
);

  // The carriers in the package fix the widths, so other values cannot fit.
  if (ADDR_W != ADDR_WIDTH || DATA_W != DATA_WIDTH) begin : g_bad_width
    $error("sbsc_top: widths must match the package carriers");
  end

  // The counter supplies only the low bits, so the address must be wider
  // than it, and the data must split evenly into byte lanes.
  if (ADDR_W <= BURST_BITS ||
      DATA_W != LANES * LANE_WIDTH) begin : g_bad_split
    $error("sbsc_top: address or lane split cannot be served");
  end

  // Sleep latency comes from the two synchroniser flops alone; any other
  // count would need a counter that this block does not have.
  if (SLEEP_CYCLES != $bits({RST_STATE.sleep_sync1,
                             RST_STATE.sleep_sync2})) begin : g_bad_sleep
    $error("sbsc_top: sleep latency is fixed by the synchroniser depth");
  end

  sbsc_state_t st;
  sbsc_state_t next_st;
  sbsc_cycle_t cycle;

  // Low address bits of the current burst step.
  function automatic logic [BURST_BITS-1:0] burst_low(
    input logic [BURST_BITS-1:0] start,
    input logic [BURST_BITS-1:0] step,
    input logic                  interleave
  );
    logic [BURST_BITS-1:0] low;
    if (interleave) begin
      low = start ^ step; // RQ7
    end else begin
      low = start + step; // RQ8
    end
    return low;
  endfunction

  // Lanes written by the write inputs; empty means a read.
  function automatic logic [LANES-1:0] write_lanes(input sbsc_bus_t bus);
    logic [LANES-1:0] lanes;
    if (!bus.global_write_n) begin
      lanes = ALL_LANES; // RQ20
    end else if (!bus.byte_write_gate_n) begin
      lanes = ~bus.byte_lane_write_n; // RQ17 RQ20
    end else begin
      lanes = NO_LANES; // RQ17
    end
    return lanes;
  endfunction

  logic                  asleep;
  logic                  sel_all;
  logic                  proc_start;
  logic                  ctrl_start;
  logic [LANES-1:0]      lanes;
  logic                  is_write;
  logic [BURST_BITS-1:0] next_low;

  always_comb begin
    asleep     = st.sleep_sync2;
    sel_all    = !BUS.chip_sel_primary_n && BUS.chip_sel_expand_hi &&
                 !BUS.chip_sel_expand_lo_n;
    // The processor strobe only counts with the primary select low.
    proc_start = !BUS.processor_addr_strobe_n && !BUS.chip_sel_primary_n; // RQ14
    // The controller strobe is ignored under an accepted processor strobe.
    ctrl_start = !BUS.controller_addr_strobe_n &&
                 BUS.processor_addr_strobe_n; // RQ1
    lanes      = write_lanes(BUS);
    is_write   = |lanes; // RQ17

    if (asleep) begin
      cycle = CYC_IDLE; // RQ13
    end else if (proc_start) begin
      cycle = sel_all ? CYC_BEGIN_READ : CYC_DESELECT; // RQ14 RQ21 RQ12
    end else if (!BUS.controller_addr_strobe_n) begin
      if (!sel_all) begin
        cycle = CYC_DESELECT; // RQ12
      end else if (ctrl_start && is_write) begin
        cycle = CYC_BEGIN_WRITE; // RQ1
      end else begin
        cycle = CYC_BEGIN_READ;
      end
    end else if (!st.active) begin
      cycle = CYC_IDLE;
    end else if (!BUS.burst_advance_n) begin
      cycle = CYC_NEXT; // RQ15
    end else begin
      cycle = CYC_CURRENT; // RQ16
    end
  end

  always_comb begin
    next_st = st;
    next_low = STEP_ZERO;

    // Two flops so a sleep level changing at any time settles first.
    next_st.sleep_sync1 = SLEEP_REQUEST; // RQ9
    next_st.sleep_sync2 = st.sleep_sync1; // RQ9 RQ10

    // The order strap is caught once, on the first enabled cycle.
    if (!st.mode_taken) begin
      next_st.interleave = BURST_ORDER_INTERLEAVE; // RQ6
      next_st.mode_taken = 1'b1;
    end

    next_st.mem.write_lanes = NO_LANES;
    next_st.mem.read        = 1'b0;
    next_st.mem.wdata       = DQ_IN;

    // Data out trails the array access by one cycle, so the drive decision
    // uses the access registered at the previous rise.
    next_st.dq_out  = MEM_RDATA;
    next_st.dq_oe_n = !(st.mem.read && !BUS.output_enable_n); // RQ19

    unique case (cycle)
      CYC_IDLE: begin
        if (asleep) begin
          // Anything pending at sleep entry is abandoned.
          next_st.active = 1'b0; // RQ10 RQ13
        end
      end
      CYC_DESELECT: begin
        next_st.active = 1'b0; // RQ12
      end
      CYC_BEGIN_READ: begin
        next_st.active   = 1'b1; // RQ14
        next_st.addr_hi  = BUS.addr[ADDR_W-1:BURST_BITS];
        next_st.start    = BUS.addr[BURST_BITS-1:0]; // RQ5
        next_st.step     = STEP_ZERO;
        next_st.mem.addr = BUS.addr;
        next_st.mem.read = 1'b1;
      end
      CYC_BEGIN_WRITE: begin
        next_st.active          = 1'b1;
        next_st.addr_hi         = BUS.addr[ADDR_W-1:BURST_BITS]; // RQ2
        next_st.start           = BUS.addr[BURST_BITS-1:0]; // RQ2 RQ5
        next_st.step            = STEP_ZERO;
        next_st.mem.addr        = BUS.addr; // RQ2
        next_st.mem.write_lanes = lanes; // RQ2 RQ18
      end
      CYC_NEXT, CYC_CURRENT: begin
        if (cycle == CYC_NEXT) begin
          // Two bits wrap by themselves, so the fourth step returns to start.
          next_st.step = st.step + STEP_ONE; // RQ5 RQ15
        end
        next_low = burst_low(st.start, next_st.step, st.interleave);
        next_st.mem.addr = {st.addr_hi, next_low}; // RQ15 RQ16
        if (is_write) begin
          next_st.mem.write_lanes = lanes; // RQ18 RQ21
        end else begin
          next_st.mem.read = 1'b1;
        end
      end
    endcase

    // A write seen at this rise turns the lines off at once, whatever the
    // output enable says, so a late enable cannot fight incoming data.
    if (cycle == CYC_BEGIN_WRITE ||
        ((cycle == CYC_NEXT || cycle == CYC_CURRENT) && is_write)) begin
      next_st.dq_oe_n = 1'b1; // RQ3 RQ19
    end
    if (cycle == CYC_DESELECT || asleep) begin
      next_st.dq_oe_n = 1'b1; // RQ12 RQ13
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      st <= RST_STATE;
    end else if (CLK_EN) begin
      st <= next_st;
    end
  end

  assign DQ_OUT      = st.dq_out;
  assign DQ_OE_N     = st.dq_oe_n;
  assign MEM         = st.mem;
  assign SLEEP_STATE = st.sleep_sync2;

endmodule

`default_nettype wire

// ===== test/sbsc_properties.sv
// Port-level properties of the burst SRAM control.
`timescale 1ns/1ps
`default_nettype none
module sbsc_properties
  import sbsc_pkg::*;
#(
  parameter int ADDR_W = ADDR_WIDTH,
  parameter int DATA_W = DATA_WIDTH
) (
  // Everything the top module shows.
  input wire logic              MCLK,
  input wire logic              RESET,
  input wire logic              CLK_EN,
  input wire logic              BURST_ORDER_INTERLEAVE,
  input wire logic              SLEEP_REQUEST,
  input wire sbsc_bus_t         BUS,
  input wire logic [DATA_W-1:0] DQ_IN,
  input wire logic [DATA_W-1:0] DQ_OUT,
  input wire logic              DQ_OE_N,
  input wire sbsc_mem_t         MEM,
  input wire logic [DATA_W-1:0] MEM_RDATA,
  input wire logic              SLEEP_STATE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  wire logic go  = CLK_EN && !SLEEP_STATE && !SLEEP_REQUEST;
  wire logic sel = !BUS.chip_sel_primary_n && BUS.chip_sel_expand_hi
                   && !BUS.chip_sel_expand_lo_n;
  wire logic wr  = !BUS.global_write_n
                   || (!BUS.byte_write_gate_n && !(&BUS.byte_lane_write_n));
  wire logic nos = BUS.processor_addr_strobe_n
                   && BUS.controller_addr_strobe_n;
  wire logic psn = BUS.processor_addr_strobe_n;
  wire logic csn = BUS.controller_addr_strobe_n;

  a_begin_read: assert property (
    go && sel && (!psn || (!csn && !wr)) |=> MEM.read
    && MEM.write_lanes == 4'h0 && MEM.addr == $past(BUS.addr))
    else $error("begin read not issued");
  a_begin_write: assert property (
    go && sel && psn && !csn && wr |=> MEM.addr == $past(BUS.addr)
    && MEM.wdata == $past(DQ_IN) && MEM.write_lanes == ($past(
    BUS.global_write_n) ? ~$past(BUS.byte_lane_write_n) : 4'hf))
    else $error("controller write wrong");
  a_write_floats: assert property (
    MEM.write_lanes != 4'h0 |-> DQ_OE_N)
    else $error("lines driven during write");
  a_deselect_quiet: assert property (
    go && !csn && BUS.chip_sel_primary_n |=> !MEM.read
    && MEM.write_lanes == 4'h0 ##1 DQ_OE_N)
    else $error("deselect made an access");
  a_sleep_entry: assert property (
    $rose(SLEEP_REQUEST) && !SLEEP_STATE |=> !SLEEP_STATE ##1 SLEEP_STATE)
    else $error("sleep entry timing wrong");
  a_sleep_quiet: assert property (
    SLEEP_STATE && $past(SLEEP_STATE) |-> DQ_OE_N && !MEM.read
    && MEM.write_lanes == 4'h0)
    else $error("activity while asleep");
  a_linear_step: assert property (
    go && nos && !BUS.burst_advance_n && !wr && MEM.read
    && !BURST_ORDER_INTERLEAVE |=> MEM.read && MEM.addr ==
    {$past(MEM.addr[ADDR_WIDTH-1:2]), $past(MEM.addr[1:0]) + 2'h1})
    else $error("linear step wrong");
  a_suspend_holds: assert property (
    go && nos && BUS.burst_advance_n && !wr && MEM.read
    |=> MEM.read && MEM.addr == $past(MEM.addr))
    else $error("suspend moved address");
endmodule

bind sbsc_top sbsc_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .MCLK(MCLK), .RESET(RESET), .CLK_EN(CLK_EN), .BUS(BUS),
  .BURST_ORDER_INTERLEAVE(BURST_ORDER_INTERLEAVE), .DQ_IN(DQ_IN),
  .SLEEP_REQUEST(SLEEP_REQUEST), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N),
  .MEM(MEM), .MEM_RDATA(MEM_RDATA), .SLEEP_STATE(SLEEP_STATE));
`default_nettype wire

// ===== test/sbsc_array_model.sv
// Storage array stand-in answering reads with an address-derived word.
`timescale 1ns/1ps
`default_nettype none
module sbsc_array_model
  import sbsc_pkg::*;
(
  // Array port of the block.
  input  wire sbsc_mem_t         mem,
  output logic [DATA_WIDTH-1:0] rdata
);
  // A pure function of the address keeps expectations simple; misplaced
  // writes are caught on the array port instead.
  assign rdata = {15'h5a5, mem.addr};
endmodule
`default_nettype wire

// ===== test/test_sync_burst_sram_control.sv
// Self-checking bench of the burst SRAM control.
`timescale 1ns/1ps
`default_nettype none
module test_sync_burst_sram_control
  import sbsc_pkg::*;
;
  logic        mclk;
  logic        reset;
  logic        strap;
  logic        sleep_req;
  sbsc_bus_t   bus;
  sbsc_bus_t   idle;
  logic [35:0] dq_in;
  logic [35:0] dq_out;
  logic [35:0] rdata;
  logic        dq_oe_n;
  sbsc_mem_t   mem;
  logic        sleep_state;
  logic        clk_en;
  int          bad_count;
  int          tests_run;
  int          cycles = 0;

  sbsc_top dut (.MCLK(mclk), .RESET(reset), .CLK_EN(clk_en), .BUS(bus),
    .BURST_ORDER_INTERLEAVE(strap), .SLEEP_REQUEST(sleep_req),
    .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .MEM(mem),
    .MEM_RDATA(rdata), .SLEEP_STATE(sleep_state));
  sbsc_array_model array (.mem(mem), .rdata(rdata));

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h, want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input sbsc_bus_t b);
    bus = b;
    @(negedge mclk);
  endtask

  task automatic do_reset(input logic order);
    reset = 1'b1;
    strap = order;
    bus = idle;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
  endtask

  task automatic s_burst(input logic il);
    sbsc_bus_t   b;
    logic [20:0] prev;
    b = idle;
    b.chip_sel_primary_n = 1'b0;
    b.processor_addr_strobe_n = 1'b0;
    b.global_write_n = 1'b0;
    b.output_enable_n = 1'b0;
    b.addr = 21'h00a5d;
    cyc(b);
    chk(mem.read, 1'b1);
    chk(mem.write_lanes, 4'h0);
    prev = mem.addr;
    b = idle;
    b.burst_advance_n = 1'b0;
    b.output_enable_n = 1'b0;
    for (int i = 1; i < 4; i++) begin
      cyc(b);
      chk(mem.addr, {19'h297, il ? 2'h1 ^ 2'(i) : 2'h1 + 2'(i)});
      chk(dq_oe_n, 1'b0);
      chk(dq_out, {15'h5a5, prev});
      prev = mem.addr;
    end
    b.burst_advance_n = 1'b1;
    b.output_enable_n = 1'b1;
    cyc(b);
    chk(mem.addr, prev);
    cyc(b);
    chk(dq_oe_n, 1'b1);
    $display("Burst test done, interleave %0d", il);
  endtask

  task automatic s_write();
    sbsc_bus_t b;
    for (int i = 0; i < 3; i++) begin
      b = idle;
      b.chip_sel_primary_n = 1'b0;
      b.controller_addr_strobe_n = 1'b0;
      b.byte_write_gate_n = (i == 2);
      b.global_write_n = (i != 2);
      b.byte_lane_write_n = i == 0 ? 4'h5 : i == 1 ? 4'he : 4'hf;
      b.addr = 21'h1ffff0 + 21'(i);
      dq_in = 36'h987654321 + 36'(i);
      cyc(b);
      chk(mem.addr, 21'h1ffff0 + 21'(i));
      chk(mem.write_lanes, i == 0 ? 4'ha : i == 1 ? 4'h1 : 4'hf);
      chk(mem.wdata, 36'h987654321 + 36'(i));
      chk(dq_oe_n, 1'b1);
    end
    b = idle;
    b.burst_advance_n = 1'b0;
    b.global_write_n = 1'b0;
    cyc(b);
    chk(mem.write_lanes, 4'hf);
    chk(mem.addr, 21'h1ffff3);
    b = idle;
    b.controller_addr_strobe_n = 1'b0;
    cyc(b);
    chk(mem.read, 1'b0);
    b.chip_sel_primary_n = 1'b0;
    b.chip_sel_expand_hi = 1'b0;
    b.processor_addr_strobe_n = 1'b0;
    cyc(b);
    chk(mem.read, 1'b0);
    chk(dq_oe_n, 1'b1);
    b = idle;
    b.chip_sel_primary_n = 1'b0;
    b.controller_addr_strobe_n = 1'b0;
    b.addr = 21'h000102;
    cyc(b);
    chk(mem.read, 1'b1);
    chk(mem.addr, 21'h000102);
    b.processor_addr_strobe_n = 1'b0;
    b.global_write_n = 1'b0;
    b.addr = 21'h000203;
    cyc(b);
    chk(mem.read, 1'b1);
    chk(mem.write_lanes, 4'h0);
    b = idle;
    b.global_write_n = 1'b0;
    dq_in = 36'h0abcdef12;
    cyc(b);
    chk(mem.addr, 21'h000203);
    chk(mem.write_lanes, 4'hf);
    chk(mem.wdata, 36'h0abcdef12);
    chk(dq_oe_n, 1'b1);
    b.burst_advance_n = 1'b0;
    clk_en = 1'b0;
    cyc(b);
    chk(mem.addr, 21'h000203);
    clk_en = 1'b1;
    cyc(b);
    chk(mem.addr, 21'h000202);
    b = idle;
    b.controller_addr_strobe_n = 1'b0;
    cyc(b);
    chk(mem.write_lanes, 4'h0);
    $display("Write and deselect test done");
  endtask

  task automatic s_sleep();
    sbsc_bus_t r;
    sbsc_bus_t b;
    r = idle;
    r.chip_sel_expand_hi = 1'b0;
    r.chip_sel_expand_lo_n = 1'b1;
    b = idle;
    b.chip_sel_primary_n = 1'b0;
    b.processor_addr_strobe_n = 1'b0;
    sleep_req = 1'b1;
    cyc(r);
    chk(sleep_state, 1'b0);
    cyc(r);
    chk(sleep_state, 1'b1);
    cyc(b);
    chk(mem.read, 1'b0);
    chk(dq_oe_n, 1'b1);
    cyc(r);
    chk(mem.read, 1'b0);
    sleep_req = 1'b0;
    cyc(r);
    chk(sleep_state, 1'b1);
    cyc(r);
    chk(sleep_state, 1'b0);
    $display("Sleep test done");
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // The ceiling sits well above the sixty-odd cycles the tests need.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 400) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    clk_en = 1'b1;
    bad_count = 0;
    tests_run = 0;
    sleep_req = 1'b0;
    dq_in = '0;
    idle = '1;
    idle.addr = '0;
    idle.chip_sel_expand_lo_n = 1'b0;
    do_reset(1'b1);
    s_burst(1'b1);
    s_write();
    s_sleep();
    do_reset(1'b0);
    s_burst(1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
